/* design/async_sync_serial_port.sv */
// serial port with asynchronous character mode and 3-wire clocked mode
// What this block does
// - two exclusive modes, asynchronous and 3-wire
// - mode register sets 3-wire and clock source
// - status reports kind of receive error
// - reading received character clears error status
// - mode register 0 holds transmit/receive enables
// - mode register 1 sets parity, length, stops
// - transmit and receive share one address
// - 7-bit length sends bits 6 to 0
// - 7-bit length receives, bit 7 reads 0
// - store writes transmit, load reads receive
// - writes ignored while async transmit runs
`timescale 1ns/1ps
`default_nettype none
module async_sync_serial_port #(
  parameter logic [15:0] BAUD_DIV = serial_port_pkg::DEF_BAUD_DIV,
  parameter logic [7:0]  SCK_HALF = serial_port_pkg::DEF_SCK_HALF
) (
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  input  wire logic [serial_port_pkg::ADDR_W-1:0] periph_addr,
  input  wire logic [7:0]                         periph_wdata,
  input  wire logic                               peripheral_store_op,
  input  wire logic                               peripheral_load_op,
  output var  logic [7:0]                         periph_rdata,
  input  wire logic                               link_clk,
  input  wire logic                               serial_in_pin,
  output var  logic                               serial_out_pin,
  output var  logic                               serial_out_oe,
  output var  logic                               shift_clock_pin,
  output var  logic                               shift_clock_oe
);
  import serial_port_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  logic [3:0]  op_mode;
  logic [3:0]  amode0;
  logic [3:0]  amode1;
  logic [2:0]  err_status;
  logic [7:0]  serial_tx_holding;
  logic [7:0]  serial_rx_buffer;
  logic        rx_full;
  logic        rx_in;
  logic        tx_line;
  tx_state_t   tx_state;
  rx_state_t   rx_state;
  logic [15:0] tx_cnt;
  logic [15:0] rx_cnt;
  logic [2:0]  tx_bit;
  logic [2:0]  rx_bit;
  logic        tx_stop2;
  logic [7:0]  rx_shreg;
  logic        rx_par;
  logic        uart_done;
  logic [7:0]  uart_char;
  logic        uart_pe;
  logic        uart_fe;
  logic        m_active;
  logic [7:0]  m_div;
  logic [2:0]  m_bit;
  logic [7:0]  m_shreg;
  logic        m_done;
  logic        s_busy;
  logic        s_done_tgl;
  logic        s_done_sync;
  logic        s_done_prev;
  logic        s_out;
  logic [7:0]  s_word;

  // mode decode; sync enable forces the asynchronous side idle
  wire sync_en   = op_mode[OPM_SYNC_EN];
  wire ext_clk   = op_mode[OPM_CLK_HI:OPM_CLK_LO] == CLK_EXTERNAL;
  wire tx_en     = amode0[AM0_TX_EN] && !sync_en;
  wire rx_en     = amode0[AM0_RX_EN] && !sync_en;
  wire char8     = amode1[AM1_CHAR8];
  wire [1:0] par = amode1[AM1_PAR_HI:AM1_PAR_LO];
  wire wr_data   = peripheral_store_op && periph_addr == ADDR_DATA;
  wire rd_data   = peripheral_load_op && periph_addr == ADDR_DATA;
  wire tx_busy   = tx_state != TX_IDLE;
  wire sync_busy = m_active || s_busy;
  wire s_done    = s_done_sync != s_done_prev;
  wire [2:0] last_bit = char8 ? LAST_BIT8 : LAST_BIT7;

  // parity of a character, shared by transmitter and receiver
  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] ps, input logic eight);
    logic p;
    p = ^{d[7] & eight, d[6:0]};
    case (ps)
      PAR_ODD:  parity_of = ~p;
      PAR_EVEN: parity_of = p;
      default:  parity_of = 1'b0;
    endcase
  endfunction

  // received line passes two flops before use on the system clock
  serial_sync2 u_rx_sync (
    .clk  (sys_clk),
    .din  (serial_in_pin),
    .dout (rx_in)
  );

  // external-clock 3-wire shifting runs on the link clock
  link_shifter u_link (
    .link_clk   (link_clk),
    .enable     (sync_en && ext_clk),
    .tx_word    (serial_tx_holding),
    .serial_in  (serial_in_pin),
    .serial_out (s_out),
    .rx_word    (s_word),
    .done_tgl   (s_done_tgl)
  );

  // completion toggle from the link domain
  serial_sync2 u_done_sync (
    .clk  (sys_clk),
    .din  (s_done_tgl),
    .dout (s_done_sync)
  );

  // control registers written by peripheral store
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_mode <= CTRL_RESET;
      amode0  <= CTRL_RESET;
      amode1  <= CTRL_RESET;
    end else if (peripheral_store_op) begin
      case (periph_addr)
        ADDR_OPMODE: op_mode <= periph_wdata[3:0];
        ADDR_AMODE0: amode0  <= periph_wdata[3:0];
        ADDR_AMODE1: amode1  <= periph_wdata[3:0]; // format taken live, so keep it still
        default: ;
      endcase
    end
  end

  // load returns the addressed register on the next edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      periph_rdata <= DATA_RESET;
    end else if (peripheral_load_op) begin
      case (periph_addr)
        ADDR_DATA:   periph_rdata <= serial_rx_buffer;
        ADDR_OPMODE: periph_rdata <= {4'h0, op_mode};
        ADDR_STATUS: periph_rdata <= {4'h0, sync_busy || tx_busy, err_status};
        ADDR_AMODE0: periph_rdata <= {4'h0, amode0};
        ADDR_AMODE1: periph_rdata <= {4'h0, amode1};
        default:     periph_rdata <= DATA_RESET;
      endcase
    end
  end

  // holding register: masked while either engine is busy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_tx_holding <= DATA_RESET;
    end else if (wr_data && !tx_busy && !sync_busy) begin
      serial_tx_holding <= periph_wdata;
    end
  end

  // asynchronous transmitter
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tx_en) begin
      tx_state <= TX_IDLE;
      tx_cnt   <= 16'h0;
      tx_bit   <= 3'h0;
      tx_stop2 <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (wr_data) begin
            tx_state <= TX_START;
            tx_cnt   <= BAUD_DIV;
          end
        end
        TX_START, TX_DATA, TX_PAR, TX_STOP: begin
          if (tx_cnt != 16'h1) begin
            tx_cnt <= tx_cnt - 16'h1;
          end else begin
            tx_cnt <= BAUD_DIV;
            case (tx_state)
              TX_START: begin
                tx_state <= TX_DATA;
                tx_bit   <= 3'h0;
              end
              TX_DATA: begin
                tx_bit <= tx_bit + 3'h1;
                if (tx_bit == last_bit) begin
                  tx_state <= (par == PAR_NONE) ? TX_STOP : TX_PAR;
                  tx_stop2 <= amode1[AM1_STOP2];
                end
              end
              TX_PAR:  tx_state <= TX_STOP;
              default: begin
                tx_stop2 <= 1'b0;
                if (!tx_stop2) begin
                  tx_state <= TX_IDLE;
                end
              end
            endcase
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // asynchronous receiver, mid-bit sampling, first stop checked
  always_ff @(posedge sys_clk) begin
    uart_done <= 1'b0;
    if (sys_rst || !rx_en) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 16'h0;
      rx_bit   <= 3'h0;
      rx_par   <= 1'b0;
      uart_pe  <= 1'b0;
      uart_fe  <= 1'b0;
    end else begin
      if (rx_cnt != 16'h0) begin
        rx_cnt <= rx_cnt - 16'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          if (!rx_in) begin
            rx_state <= RX_START;
            rx_cnt   <= (BAUD_DIV >> 1) - 16'h1; // the synchroniser already ate part of the start bit
          end
        end
        RX_START: begin
          if (rx_cnt == 16'h0) begin
            rx_state <= rx_in ? RX_IDLE : RX_DATA; // glitch rejected
            rx_cnt   <= BAUD_DIV - 16'h1; // counts down to zero, so one less
            rx_bit   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_cnt == 16'h0) begin
            rx_shreg <= {rx_in, rx_shreg[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            rx_cnt   <= BAUD_DIV - 16'h1;
            if (rx_bit == last_bit) begin
              rx_state <= (par == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt == 16'h0) begin
            rx_par   <= rx_in;
            rx_state <= RX_STOP;
            rx_cnt   <= BAUD_DIV - 16'h1;
          end
        end
        RX_STOP: begin
          if (rx_cnt == 16'h0) begin
            uart_char <= char8 ? rx_shreg : {1'b0, rx_shreg[7:1]};
            uart_pe   <= par != PAR_NONE && rx_par != parity_of(rx_shreg >> !char8, par, char8);
            uart_fe   <= !rx_in;
            uart_done <= 1'b1;
            rx_state  <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // internal-clock 3-wire master, msb first, clock idles high
  always_ff @(posedge sys_clk) begin
    m_done <= 1'b0;
    if (sys_rst || !sync_en || ext_clk) begin
      m_active        <= 1'b0;
      m_div           <= 8'h0;
      m_bit           <= 3'h0;
      shift_clock_pin <= 1'b1;
    end else if (!m_active) begin
      if (wr_data && !sync_busy) begin
        m_active <= 1'b1;
        m_div    <= SCK_HALF;
        m_bit    <= 3'h0;
      end
    end else if (m_div != 8'h1) begin
      m_div <= m_div - 8'h1;
    end else begin
      m_div           <= SCK_HALF;
      shift_clock_pin <= ~shift_clock_pin;
      if (!shift_clock_pin) begin
        m_shreg <= {m_shreg[6:0], rx_in};
        m_bit   <= m_bit + 3'h1;
        if (m_bit == LAST_BIT8) begin
          m_active <= 1'b0;
          m_done   <= 1'b1;
        end
      end
    end
  end

  // line driver for asynchronous and master modes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_line <= 1'b1;
    end else if (!sync_en) begin
      case (tx_state)
        TX_START: tx_line <= 1'b0;
        TX_DATA:  tx_line <= serial_tx_holding[tx_bit];
        TX_PAR:   tx_line <= parity_of(serial_tx_holding, par, char8);
        default:  tx_line <= 1'b1;
      endcase
    end else if (m_active && shift_clock_pin && m_div == 8'h1) begin
      tx_line <= serial_tx_holding[3'h7 - m_bit];
    end
  end

  // pin enables follow the active mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_out_oe  <= 1'b0;
      shift_clock_oe <= 1'b0;
    end else begin
      serial_out_oe  <= sync_en ? op_mode[OPM_SYNC_OUT] : tx_en;
      shift_clock_oe <= sync_en && !ext_clk;
    end
  end

  // slave transfer tracking across the domains
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_busy      <= 1'b0;
      s_done_prev <= 1'b0;
    end else begin
      s_done_prev <= s_done_sync;
      if (wr_data && sync_en && ext_clk && !sync_busy) begin
        s_busy <= 1'b1;
      end else if (s_done || !sync_en) begin
        s_busy <= 1'b0;
      end
    end
  end

  // receive buffer; a new completion wins over a read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_rx_buffer <= DATA_RESET;
      rx_full          <= 1'b0;
    end else if (uart_done || m_done || s_done) begin
      serial_rx_buffer <= uart_done ? uart_char : (m_done ? m_shreg : s_word);
      rx_full          <= 1'b1;
    end else if (rd_data) begin
      rx_full <= 1'b0;
    end
  end

  // error flags: cleared by reading the data, set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      err_status <= 3'h0;
    end else if (uart_done) begin
      err_status[ST_PE]  <= uart_pe || (err_status[ST_PE] && !rd_data);
      err_status[ST_FE]  <= uart_fe || (err_status[ST_FE] && !rd_data);
      err_status[ST_OVE] <= (rx_full && !rd_data) || (err_status[ST_OVE] && !rd_data);
    end else if (rd_data) begin
      err_status <= 3'h0;
    end
  end

  // slave mode drives from the link-domain flop
  assign serial_out_pin = (sync_en && ext_clk) ? s_out : tx_line;

  a_write_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_data && tx_busy) |=> $stable(serial_tx_holding)) else $error("holding changed during transmit");
  a_store_loads: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_data && !tx_busy && !sync_busy) |=> serial_tx_holding == $past(periph_wdata))
    else $error("store did not load holding");
  a_load_returns: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_data |=> periph_rdata == $past(serial_rx_buffer)) else $error("load returned wrong data");
  a_read_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_data && !uart_done) |=> err_status == 3'h0) else $error("read did not clear status");
  a_bit7_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (uart_done && !char8) |=> !serial_rx_buffer[7]) else $error("bit 7 set in 7-bit mode");
  a_start_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tx_state == TX_IDLE && tx_en && wr_data) |=> ##1 !tx_line) else $error("no start bit");
  a_overrun_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (uart_done && rx_full && !rd_data) |=> err_status[ST_OVE]) else $error("overrun missed");
  a_modes_exclusive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sync_en |=> tx_state == TX_IDLE && rx_state == RX_IDLE) else $error("async active in 3-wire");
endmodule // async_sync_serial_port
`default_nettype wire

/* design/serial_port_pkg.sv */
// constants shared by the serial port design files
package serial_port_pkg;
  // peripheral address width and register addresses
  localparam int unsigned ADDR_W      = 7;
  localparam logic [6:0]  ADDR_DATA   = 7'h05;
  localparam logic [6:0]  ADDR_OPMODE = 7'h06;
  localparam logic [6:0]  ADDR_STATUS = 7'h07;
  localparam logic [6:0]  ADDR_AMODE0 = 7'h08;
  localparam logic [6:0]  ADDR_AMODE1 = 7'h09;
  // operation mode register fields
  localparam int unsigned OPM_SYNC_EN  = 3;
  localparam int unsigned OPM_SYNC_OUT = 2;
  localparam int unsigned OPM_CLK_HI   = 1;
  localparam int unsigned OPM_CLK_LO   = 0;
  localparam logic [1:0]  CLK_EXTERNAL = 2'h0;
  // asynchronous mode register 0 fields
  localparam int unsigned AM0_TX_EN = 3;
  localparam int unsigned AM0_RX_EN = 2;
  // asynchronous mode register 1 fields
  localparam int unsigned AM1_PAR_HI = 3;
  localparam int unsigned AM1_PAR_LO = 2;
  localparam int unsigned AM1_CHAR8  = 1;
  localparam int unsigned AM1_STOP2  = 0;
  localparam logic [1:0]  PAR_NONE   = 2'h0;
  localparam logic [1:0]  PAR_ZERO   = 2'h1;
  localparam logic [1:0]  PAR_ODD    = 2'h2;
  localparam logic [1:0]  PAR_EVEN   = 2'h3;
  // status register fields
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_PE   = 2;
  localparam int unsigned ST_FE   = 1;
  localparam int unsigned ST_OVE  = 0;
  // reset values and default timing counts
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [15:0] DEF_BAUD_DIV = 16'h015b;
  localparam logic [7:0]  DEF_SCK_HALF = 8'h14;
  localparam logic [2:0]  LAST_BIT8    = 3'h7;
  localparam logic [2:0]  LAST_BIT7    = 3'h6;
endpackage

/* design/serial_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module serial_sync2 (
  input  wire logic clk,
  input  wire logic din,
  output var  logic dout
);
  logic meta;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end
endmodule // serial_sync2
`default_nettype wire

/* design/link_shifter.sv */
// 3-wire shifter clocked by the external shift clock
`timescale 1ns/1ps
`default_nettype none
module link_shifter (
  input  wire logic       link_clk,
  input  wire logic       enable,
  input  wire logic [7:0] tx_word,
  input  wire logic       serial_in,
  output var  logic       serial_out,
  output var  logic [7:0] rx_word,
  output var  logic       done_tgl
);
  logic       enable_s;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;

  // enable level crosses into the link domain
  serial_sync2 u_en_sync (
    .clk  (link_clk),
    .din  (enable),
    .dout (enable_s)
  );

  // sample on rising edge; the clock may stop between frames
  always_ff @(posedge link_clk) begin
    if (!enable_s) begin
      bit_cnt  <= 3'h0;
      done_tgl <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= {shreg[6:0], serial_in};
      if (bit_cnt == 3'h7) begin
        rx_word  <= {shreg[6:0], serial_in};
        done_tgl <= ~done_tgl; // event crosses as a toggle
      end
    end
  end

  // drive on falling edge; tx_word is held stable during a frame
  always_ff @(negedge link_clk) begin
    serial_out <= tx_word[3'h7 - bit_cnt];
  end
endmodule // link_shifter
`default_nettype wire

/* verification/serial_peer.sv */
// behavioural remote serial peer: uart frames, 3-wire slave and 3-wire master
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT_NS = 100
) (
  input  wire logic serial_out_pin,
  input  wire logic shift_clock_pin,
  output var  logic serial_in_pin,
  output var  logic link_clk
);
  logic [7:0] sl_tx;
  logic [7:0] sl_rx;
  logic       sl_en;

  // line and link clock idle high, clock stands still outside frames
  initial begin
    serial_in_pin = 1'b1;
    link_clk      = 1'b1;
    sl_en         = 1'b0;
    sl_tx         = 8'h00;
    sl_rx         = 8'h00;
  end

  // frame bits go out lsb first, then the line returns to idle
  task automatic send_bits(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin = bits[i];
      #(BIT_NS);
    end
    serial_in_pin = 1'b1;
  endtask

  // bounded wait for the start edge, then sample in mid bit
  task automatic recv_bits(output logic [11:0] bits, input int n);
    int t;
    bits = 12'h000;
    t = 0;
    while (serial_out_pin !== 1'b0 && t < 20000) begin
      t++;
      #1;
    end
    #(BIT_NS / 2);
    for (int i = 0; i < n; i++) begin
      bits[i] = serial_out_pin;
      #(BIT_NS);
    end
  endtask

  // slave on the internal shift clock: drive at falling, sample at rising, msb first
  always @(negedge shift_clock_pin) begin
    if (sl_en) begin
      serial_in_pin <= sl_tx[7];
      sl_tx         <= {sl_tx[6:0], 1'b0};
    end
  end
  always @(posedge shift_clock_pin) begin
    if (sl_en) begin
      sl_rx <= {sl_rx[6:0], serial_out_pin};
    end
  end

  // master on the link clock, 125 ns period, offset so edges miss the system clock
  task automatic clock_byte(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    #3.1;
    // two idle pulses let the slave enable cross into the link domain
    repeat (2) begin
      link_clk = 1'b0;
      #62.5;
      link_clk = 1'b1;
      #62.5;
    end
    for (int i = 7; i >= 0; i--) begin
      link_clk      = 1'b0;
      serial_in_pin = tx[i];
      #62.5;
      link_clk = 1'b1;
      rx[i]    = serial_out_pin;
      #62.5;
    end
    serial_in_pin = 1'b1;
  endtask
endmodule // serial_peer
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the serial port: uart and 3-wire traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_port_pkg::*;
  logic              sys_clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] periph_addr;
  logic [7:0]        periph_wdata;
  logic              peripheral_store_op;
  logic              peripheral_load_op;
  logic [7:0]        periph_rdata;
  logic              link_clk;
  logic              serial_in_pin;
  logic              serial_out_pin;
  logic              serial_out_oe;
  logic              shift_clock_pin;
  logic              shift_clock_oe;
  int                miscompares;
  int                check_count;
  integer            seed;
  logic [7:0]        d;
  logic [7:0]        r;
  logic [7:0]        got8;
  logic [11:0]       got;
  logic [11:0]       exp;
  int                n;
  int                e;

  // short baud and shift counts keep the run brief; bit time is 4 cycles
  // shift half period covers the two-flop delay on the returned data
  async_sync_serial_port #(.BAUD_DIV(16'h0004), .SCK_HALF(8'h04)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .periph_addr(periph_addr), .periph_wdata(periph_wdata),
    .peripheral_store_op(peripheral_store_op), .peripheral_load_op(peripheral_load_op),
    .periph_rdata(periph_rdata), .link_clk(link_clk), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .shift_clock_pin(shift_clock_pin), .shift_clock_oe(shift_clock_oe));
  serial_peer #(.BIT_NS(100)) u_peer (
    .serial_out_pin(serial_out_pin), .shift_clock_pin(shift_clock_pin),
    .serial_in_pin(serial_in_pin), .link_clk(link_clk));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  // one-cycle strobe, then an idle cycle so a strobe is never re-driven in one step
  task automatic store(input logic [6:0] a, input logic [7:0] v);
    periph_addr         = a;
    periph_wdata        = v;
    peripheral_store_op = 1'b1;
    @(negedge sys_clk);
    peripheral_store_op = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic chk_rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] want);
    periph_addr        = a;
    peripheral_load_op = 1'b1;
    @(negedge sys_clk);
    peripheral_load_op = 1'b0;
    @(negedge sys_clk);
    check(12'(periph_rdata & m), 12'(want & m));
  endtask

  // bounded poll of the busy flag
  task automatic wait_idle;
    int t;
    t = 0;
    periph_addr = ADDR_STATUS;
    do begin
      peripheral_load_op = 1'b1;
      @(negedge sys_clk);
      peripheral_load_op = 1'b0;
      @(negedge sys_clk);
      t++;
    end while (periph_rdata[ST_BUSY] !== 1'b0 && t < 200);
    if (t >= 200) begin
      miscompares++;
      stop_test();
    end
  endtask

  // expected frame: start, data lsb first, optional parity, stops; n counts bits
  function automatic logic [11:0] frame(input logic [7:0] v, input logic [3:0] fmt, output int n);
    logic [7:0]  m;
    logic        p;
    logic [11:0] f;
    m = fmt[AM1_CHAR8] ? v : {1'b0, v[6:0]};
    p = (fmt[AM1_PAR_HI:AM1_PAR_LO] == PAR_ODD) ? ~^m : ^m;
    if (fmt[AM1_PAR_HI:AM1_PAR_LO] == PAR_ZERO) p = 1'b0;
    f = 12'hffe;
    n = 1;
    for (int i = 0; i < (fmt[AM1_CHAR8] ? 8 : 7); i++) begin
      f[n] = m[i];
      n++;
    end
    if (fmt[AM1_PAR_HI:AM1_PAR_LO] != PAR_NONE) begin
      f[n] = p;
      n++;
    end
    n += fmt[AM1_STOP2] ? 2 : 1;
    return f;
  endfunction

  initial begin
    seed = 32'h2913fc0b;
    miscompares = 0;
    check_count = 0;
    sys_rst = 1'b1;
    periph_addr = 7'h00;
    periph_wdata = 8'h00;
    peripheral_store_op = 1'b0;
    peripheral_load_op = 1'b0;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    // reset state of pins and control registers, unmapped address reads zero
    check(12'({serial_out_pin, shift_clock_pin, serial_out_oe, shift_clock_oe}), 12'h00c);
    for (int a = 6; a <= 10; a++) chk_rd(7'(a), 8'hff, 8'h00);
    // every frame format: transmit, refused second write, then receive with an error kind
    for (int f = 0; f < 16; f++) begin
      store(ADDR_AMODE0, 8'h00);
      store(ADDR_AMODE1, f[7:0]);
      chk_rd(ADDR_AMODE1, 8'hff, f[7:0]);
      store(ADDR_AMODE0, 8'h0c);
      d = 8'($random(seed));
      exp = frame(d, f[3:0], n);
      fork
        u_peer.recv_bits(got, n);
        begin
          store(ADDR_DATA, d);
          store(ADDR_DATA, ~d);
          check(12'(serial_out_oe), 12'h001);
          chk_rd(ADDR_STATUS, 8'h08, 8'h08);
        end
      join
      check(got, exp & ((12'h001 << n) - 12'h001));
      #100;
      check(12'(serial_out_pin), 12'h001);
      d = 8'($random(seed));
      exp = frame(d, f[3:0], n);
      e = (f == 0) ? 2 : ((f == 12) ? 1 : int'({$random(seed)} % 3));
      if (e == 1 && f[3]) exp[n - (f[0] ? 3 : 2)] = ~exp[n - (f[0] ? 3 : 2)];
      if (e == 2) exp[n - (f[0] ? 2 : 1)] = 1'b0;
      u_peer.send_bits(exp, n);
      repeat (4) @(negedge sys_clk);
      chk_rd(ADDR_STATUS, 8'h07, {5'h00, e == 1 && f[3] == 1'b1, e == 2, 1'b0});
      chk_rd(ADDR_DATA, 8'hff, f[1] ? d : {1'b0, d[6:0]});
      chk_rd(ADDR_STATUS, 8'h07, 8'h00);
    end
    // two characters with no read between them overrun the buffer
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      exp = frame(d, 4'hf, n);
      u_peer.send_bits(exp, n);
    end
    repeat (4) @(negedge sys_clk);
    chk_rd(ADDR_STATUS, 8'h07, 8'h01);
    chk_rd(ADDR_DATA, 8'hff, d);
    chk_rd(ADDR_STATUS, 8'h07, 8'h00);
    // 3-wire with internal clock, async enables cleared first
    store(ADDR_AMODE0, 8'h00);
    store(ADDR_OPMODE, 8'h0d);
    chk_rd(ADDR_OPMODE, 8'hff, 8'h0d);
    check(12'({shift_clock_oe, serial_out_oe}), 12'h003);
    d = 8'($random(seed));
    r = 8'($random(seed));
    u_peer.sl_tx = r;
    u_peer.sl_en = 1'b1;
    store(ADDR_DATA, d);
    wait_idle();
    u_peer.sl_en = 1'b0;
    chk_rd(ADDR_DATA, 8'hff, r);
    check(12'(u_peer.sl_rx), 12'(d));
    check(12'(shift_clock_pin), 12'h001);
    // 3-wire with the peer's link clock
    store(ADDR_OPMODE, 8'h0c);
    check(12'(shift_clock_oe), 12'h000);
    d = 8'h81;
    r = 8'($random(seed));
    store(ADDR_DATA, d);
    u_peer.clock_byte(r, got8);
    repeat (8) @(negedge sys_clk);
    chk_rd(ADDR_DATA, 8'hff, r);
    check(12'(got8), 12'(d));
    stop_test();
  end
endmodule // testbench
`default_nettype wire
